/* File: hw/efic_pkg.sv */
// package: register map, field layout and types of the edge flag interrupt combiner
package efic_pkg;
	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] EFIC_IDX_LIVE   = 8'h0d;
	localparam logic [7:0] EFIC_IDX_MASK   = 8'h0e;
	localparam logic [7:0] EFIC_IDX_POL    = 8'h0f;
	localparam logic [7:0] EFIC_IDX_FLAG   = 8'h10;
	localparam logic [7:0] EFIC_IDX_CTL    = 8'h11;
	localparam logic [7:0] EFIC_IDX_EVSTAT = 8'h12;
	localparam logic [7:0] EFIC_IDX_EVMASK = 8'h13;
	localparam int         EFIC_IDX_SHIFT  = 2;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int         EFIC_CTL_EN_BIT  = 0;
	localparam int         EFIC_CTL_AND_BIT = 1;
	localparam int         EFIC_NSRC        = 8;
	localparam logic [7:0] EFIC_RST_POL     = 8'h00;
	localparam logic [7:0] EFIC_RST_FLAG    = 8'h00;
	localparam logic [7:0] EFIC_RST_MASK    = 8'h00;
	localparam logic [1:0] EFIC_RST_CTL     = 2'h0;
	localparam logic [7:0] EFIC_RST_EVSTAT  = 8'h00;
	localparam logic [7:0] EFIC_RST_EVMASK  = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	// bit order of every per-source register, top bit first
	typedef struct packed {
		logic pll1_unlock_src;
		logic pll1_input_lost_src;
		logic pll1_vco_cal_src;
		logic pll2_unlock_src;
		logic pll2_input_lost_src;
		logic pll2_vco_cal_src;
		logic pll1_ref_return_src;
		logic pll2_ref_return_src;
	} efic_src_s;

	typedef struct packed {
		logic and_sel;
		logic int_en;
	} efic_ctl_s;

	typedef enum logic [1:0] {
		EFIC_BUS_IDLE,
		EFIC_BUS_RDWAIT,
		EFIC_BUS_RDDONE
	} efic_bus_e;
endpackage

/* File: hw/efic_top.sv */
// edge flag interrupt combiner: source edge flags, mask, and/or combine, ahb-lite registers
//
// Functional notes
// R1: polarity register, one bit per source, resets zero
// R2: polarity one sets flag on rising edge
// R3: polarity zero sets flag on falling edge
// R4: eight sticky flags, set only by selected edge
// R5: writing zero clears a flag, else kept
// R6: flags update only while interrupt enable is one
// R7: combine bit one: all unmasked flags required
// R8: combine bit zero: any unmasked flag suffices
// R9: masked sources never activate the interrupt
// R10: enable zero blocks status output, live continues
// R11: lost input suppresses that pll's unlock source
// R12: edges found by comparing sample with previous
`timescale 1ns/10ps
`default_nettype none
module efic_top
	import efic_pkg::*;
(
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// ahb-lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// raw internal status sources
	input  wire efic_pkg::efic_src_s src_raw,
	// combined interrupt towards the status pins
	output logic                   status_int,
	// software interrupt
	output logic                   irq
);
	import efic_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] word_index(input logic [31:0] a);
		word_index = a[EFIC_IDX_SHIFT +: 8];
	endfunction

	function automatic logic [7:0] edge_hit(input logic [7:0] cur, input logic [7:0] prev,
	                                        input logic [7:0] pol);
		edge_hit = (pol & cur & ~prev) | (~pol & ~cur & prev);
	endfunction

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	logic [7:0] live_q;
	logic [7:0] prev_q;
	logic [7:0] pol_q;
	logic [7:0] flag_q;
	logic [7:0] mask_q;
	efic_ctl_s  ctl_q;
	logic [7:0] evstat_q;
	logic [7:0] evmask_q;
	logic [7:0] set_evt;
	logic [7:0] live_d;
	logic       combo;

	efic_bus_e  bus_q;
	logic       ap_wr_q;
	logic       ap_rd_q;
	logic [7:0] ap_idx_q;
	logic [31:0] hrdata_q;
	logic       addr_take;
	logic       wr_now;
	logic       rd_clear;
	logic [7:0] rd_mux;

	// ----------------------------------------------------------------
	// source conditioning and edge detection
	// ----------------------------------------------------------------
	always_comb begin
		live_d = src_raw;
		// a lost input hides the unlock it causes on the same pll
		live_d[7] = src_raw.pll1_unlock_src & ~src_raw.pll1_input_lost_src; // [R11]
		live_d[4] = src_raw.pll2_unlock_src & ~src_raw.pll2_input_lost_src; // [R11]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			live_q <= 8'h00;
			prev_q <= 8'h00;
		end else begin
			live_q <= live_d;
			prev_q <= live_q; // [R12]
		end
	end

	assign set_evt = edge_hit(live_q, prev_q, pol_q); // [R2] [R3] [R12]

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	assign addr_take = hsel & htrans[1] & hready;
	assign wr_now    = ap_wr_q & (bus_q == EFIC_BUS_IDLE);
	assign rd_clear  = (bus_q == EFIC_BUS_RDWAIT) & (ap_idx_q == EFIC_IDX_EVSTAT);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q  <= 1'b0;
			ap_rd_q  <= 1'b0;
			ap_idx_q <= 8'h00;
		end else if (hready) begin
			ap_wr_q  <= addr_take & hwrite;
			ap_rd_q  <= addr_take & ~hwrite;
			ap_idx_q <= word_index(haddr);
		end
	end

	// reads take two wait states so a write just before is always visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q <= EFIC_BUS_IDLE;
		end else begin
			case (bus_q)
				EFIC_BUS_IDLE: begin
					// hready is low here for a read, so it must not gate the step
					if (ap_rd_q)
						bus_q <= EFIC_BUS_RDWAIT;
				end
				EFIC_BUS_RDWAIT: bus_q <= EFIC_BUS_RDDONE;
				EFIC_BUS_RDDONE: bus_q <= EFIC_BUS_IDLE;
				default:         bus_q <= EFIC_BUS_IDLE;
			endcase
		end
	end

	// a read in flight must not be answered until its data is captured
	assign hreadyout = ~(bus_q == EFIC_BUS_RDWAIT) & ~(ap_rd_q & (bus_q == EFIC_BUS_IDLE));
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	always_comb begin
		case (ap_idx_q)
			EFIC_IDX_LIVE:   rd_mux = live_q; // [R10]
			EFIC_IDX_MASK:   rd_mux = mask_q;
			EFIC_IDX_POL:    rd_mux = pol_q;
			EFIC_IDX_FLAG:   rd_mux = flag_q;
			EFIC_IDX_CTL:    rd_mux = {6'h00, ctl_q};
			EFIC_IDX_EVSTAT: rd_mux = evstat_q;
			EFIC_IDX_EVMASK: rd_mux = evmask_q;
			default:         rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_q <= 32'h0000_0000;
		else if (bus_q == EFIC_BUS_RDWAIT)
			hrdata_q <= {24'h00_0000, rd_mux};
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pol_q    <= EFIC_RST_POL; // [R1]
			mask_q   <= EFIC_RST_MASK;
			ctl_q    <= EFIC_RST_CTL;
			evmask_q <= EFIC_RST_EVMASK;
		end else if (wr_now) begin
			if (ap_idx_q == EFIC_IDX_POL)
				pol_q <= hwdata[7:0]; // [R1]
			if (ap_idx_q == EFIC_IDX_MASK)
				mask_q <= hwdata[7:0];
			if (ap_idx_q == EFIC_IDX_CTL)
				ctl_q <= hwdata[EFIC_CTL_AND_BIT:EFIC_CTL_EN_BIT];
			if (ap_idx_q == EFIC_IDX_EVMASK)
				evmask_q <= hwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// sticky flags; a set in the cycle of a clearing write wins
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_q <= EFIC_RST_FLAG; // [R4]
		end else if (ctl_q.int_en) begin // [R6]
			if (wr_now && ap_idx_q == EFIC_IDX_FLAG)
				flag_q <= (flag_q & hwdata[7:0]) | set_evt; // [R5]
			else
				flag_q <= flag_q | set_evt; // [R4]
		end
	end

	// ----------------------------------------------------------------
	// combination
	// ----------------------------------------------------------------
	always_comb begin
		if (ctl_q.and_sel)
			combo = (&(flag_q | mask_q)) & (|(~mask_q)); // [R7] [R9]
		else
			combo = |(flag_q & ~mask_q); // [R8] [R9]
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			status_int <= 1'b0;
		else
			status_int <= ctl_q.int_en & combo; // [R10]
	end

	// ----------------------------------------------------------------
	// software event status: each new flag edge, cleared by reading
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			evstat_q <= EFIC_RST_EVSTAT;
		else if (rd_clear)
			evstat_q <= ctl_q.int_en ? set_evt : 8'h00;
		else if (ctl_q.int_en)
			evstat_q <= evstat_q | set_evt;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(evstat_q & evmask_q);
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_pol_write;
		wr_now && ap_idx_q == EFIC_IDX_POL;
	endsequence

	AST_POL_STORE: assert property (s_pol_write |=> pol_q == $past(hwdata[7:0])) // [R1]
		else $error("polarity write not stored");
	AST_RISE_SET: assert property (ctl_q.int_en && |(pol_q & live_q & ~prev_q) // [R2]
		|=> |(flag_q & $past(pol_q & live_q & ~prev_q)))
		else $error("rising edge did not set flag");
	AST_FALL_SET: assert property (ctl_q.int_en && |(~pol_q & ~live_q & prev_q) // [R3]
		|=> (flag_q & $past(~pol_q & ~live_q & prev_q)) == $past(~pol_q & ~live_q & prev_q))
		else $error("falling edge did not set flag");
	AST_NO_SPURIOUS: assert property (!(wr_now && ap_idx_q == EFIC_IDX_FLAG) && set_evt == 8'h00 // [R4]
		|=> flag_q == $past(flag_q))
		else $error("flag changed without cause");
	AST_CLEAR: assert property (ctl_q.int_en && wr_now && ap_idx_q == EFIC_IDX_FLAG // [R5]
		|=> flag_q == (($past(flag_q) & $past(hwdata[7:0])) | $past(set_evt)))
		else $error("flag clear wrong");
	AST_FROZEN: assert property (!ctl_q.int_en |=> $stable(flag_q)) // [R6]
		else $error("flags moved while disabled");
	AST_AND: assert property (ctl_q.int_en && ctl_q.and_sel |=> status_int == $past(combo) // [R7]
		&& ($past((flag_q | mask_q) != 8'hff) -> !status_int))
		else $error("and combine wrong");
	AST_OR: assert property (ctl_q.int_en && !ctl_q.and_sel && |(flag_q & ~mask_q) |=> status_int) // [R8]
		else $error("or combine missed flag");
	AST_MASKED: assert property (!ctl_q.and_sel && (flag_q & ~mask_q) == 8'h00 |=> !status_int) // [R9]
		else $error("masked flag raised interrupt");
	AST_DISABLED: assert property (!ctl_q.int_en |=> !status_int ##0 live_q == $past(live_d)) // [R10]
		else $error("disabled interrupt reached status pin");
	AST_LOS_WINS: assert property (src_raw.pll1_input_lost_src |=> !live_q[7]) // [R11]
		else $error("unlock shown while input lost");
	AST_EDGE_PIPE: assert property (1'b1 |=> prev_q == $past(live_q) ##1 prev_q == $past(live_d, 2)) // [R12]
		else $error("edge pipeline broken");

	// bit 0 walked end to end in or mode: edge, flag, then status pin
	logic or_path0;
	assign or_path0 = ctl_q.int_en & ~ctl_q.and_sel & ~mask_q[0];

	sequence s_rise_to_flag0;
		live_d[0] && !live_q[0] ##1 or_path0 && pol_q[0];
	endsequence

	sequence s_fall_to_flag0;
		!live_d[0] && live_q[0] ##1 or_path0 && !pol_q[0];
	endsequence

	sequence s_read_answer;
		!hreadyout ##1 !hreadyout ##1 hreadyout;
	endsequence

	AST_RISE_PIN: assert property (s_rise_to_flag0 ##1 or_path0 |=> status_int) // [R2] [R8]
		else $error("rising edge on bit 0 did not reach status pin");
	AST_FALL_PIN: assert property (s_fall_to_flag0 ##1 or_path0 |=> status_int) // [R3] [R8]
		else $error("falling edge on bit 0 did not reach status pin");
	AST_ALL_MASKED: assert property (ctl_q.and_sel && mask_q == 8'hff |=> !status_int) // [R7] [R9]
		else $error("and combine fired with every source masked");
	AST_PLL2_INPUT_LOST_SRC_WINS: assert property (src_raw.pll2_input_lost_src |=> !live_q[4]) // [R11]
		else $error("pll2 unlock shown while input lost");
	// writes never wait, so a flag clear lands in its own data phase
	AST_WR_NOWAIT: assert property (ap_wr_q |-> hreadyout) // [R5]
		else $error("write data phase stalled");
	AST_RD_ANSWER: assert property (addr_take && !hwrite |=> s_read_answer) // [R10]
		else $error("read not answered after two wait states");
endmodule
`default_nettype wire

/* File: dv/edge_flag_interrupt_combiner_bench.sv */
// self-checking bench of the edge flag interrupt combiner, with a reference model
`timescale 1ns/10ps
`default_nettype none
module edge_flag_interrupt_combiner_bench;
	import efic_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, status_int, irq;
	wire logic   hready;
	logic [31:0] haddr, hwdata, hrdata, rnd, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	efic_src_s   src_raw;
	logic [7:0]  pol, flg, msk, lv, ev, evm, ctl;
	int          failures, total_checks;

	// ----------------------------------------------------------------
	// device and clock
	// ----------------------------------------------------------------
	// single slave: its ready is the bus ready
	assign hready = hreadyout;
	efic_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .src_raw(src_raw), .status_int(status_int), .irq(irq));
	always #20 hclk = ~hclk;

	// ----------------------------------------------------------------
	// model and helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'h0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	// lost input hides the unlock source of the same pll
	function automatic logic [7:0] prec(input logic [7:0] s);
		return s & ~{s[6], 2'h0, s[3], 4'h0};
	endfunction
	function automatic logic exp_int();
		if (!ctl[0]) return 1'h0;
		if (ctl[1]) return (msk != 8'hff) && ((flg | msk) == 8'hff);
		return |(flg & ~msk);
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// waits sample the combinational ready at the falling edge, where it has settled
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rv);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		do @(negedge hclk); while (hreadyout !== 1'h1);
		@(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(negedge hclk); while (hreadyout !== 1'h1);
		rv = hrdata;
		@(posedge hclk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		bus(1'h1, idx, d, rd);
	endtask
	task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		bus(1'h0, idx, 32'h0, rd);
		chk(nm, rd, exp);
	endtask
	// sources change only here, never while a bus transfer is in flight
	task automatic step(input logic [7:0] s);
		logic [7:0] nl, e;
		@(posedge hclk);
		src_raw <= efic_src_s'(s);
		repeat (4) @(posedge hclk);
		nl = prec(s);
		e = (pol & nl & ~lv) | (~pol & ~nl & lv);
		if (ctl[0]) begin
			flg |= e;
			ev |= e;
		end
		lv = nl;
		@(negedge hclk);
		chk("status_int", {31'h0, status_int}, {31'h0, exp_int()});
		chk("irq", {31'h0, irq}, {31'h0, |(ev & evm)});
		rdchk("live", EFIC_IDX_LIVE, {24'h0, lv});
		rdchk("flag", EFIC_IDX_FLAG, {24'h0, flg});
	endtask
	task automatic run(input int n);
		repeat (n) begin
			rnd = lfsr(rnd);
			step(rnd[7:0]);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		#(20000 * 40);
		failures++;
		finish_test();
	end
	initial begin
		hclk = 1'h0;
		hresetn = 1'h0;
		{hsel, hwrite, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		src_raw = '0;
		{pol, flg, msk, lv, ev, evm, ctl} = '0;
		rnd = 32'h3412b970;
		failures = 0;
		total_checks = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		for (int i = 8'h0d; i <= 8'h14; i++) rdchk("reset", 8'(i), 32'h0);
		wr(8'h14, 32'hffffffff);
		rdchk("unmapped", 8'h14, 32'h0);
		$display("test reset done");
		rnd = lfsr(rnd);
		wr(EFIC_IDX_POL, rnd);
		pol = rnd[7:0];
		rdchk("pol", EFIC_IDX_POL, {24'h0, pol});
		ctl = 8'h01;
		wr(EFIC_IDX_CTL, 32'h1);
		run(16);
		pol = ~pol;
		wr(EFIC_IDX_POL, {24'h0, pol});
		run(16);
		$display("test edges done");
		rnd = lfsr(rnd);
		wr(EFIC_IDX_FLAG, rnd);
		flg &= rnd[7:0];
		rdchk("flag clear", EFIC_IDX_FLAG, {24'h0, flg});
		wr(EFIC_IDX_FLAG, 32'hff);
		rdchk("flag keep", EFIC_IDX_FLAG, {24'h0, flg});
		run(6);
		$display("test clear done");
		ctl = 8'h03;
		wr(EFIC_IDX_CTL, 32'h3);
		for (int k = 0; k < 3; k++) begin
			msk = (k == 0) ? ~flg : (k == 1) ? (~flg ^ 8'h01) : 8'hff;
			wr(EFIC_IDX_MASK, {24'h0, msk});
			step(src_raw);
		end
		rnd = lfsr(rnd);
		msk = rnd[7:0];
		wr(EFIC_IDX_MASK, {24'h0, msk});
		run(8);
		ctl = 8'h01;
		wr(EFIC_IDX_CTL, 32'h1);
		run(8);
		$display("test combine done");
		ctl = 8'h00;
		wr(EFIC_IDX_CTL, 32'h0);
		run(10);
		wr(EFIC_IDX_FLAG, 32'h0);
		step(src_raw);
		$display("test disable done");
		ctl = 8'h01;
		wr(EFIC_IDX_CTL, 32'h1);
		evm = 8'hff;
		wr(EFIC_IDX_EVMASK, {24'h0, evm});
		run(8);
		rdchk("evstat", EFIC_IDX_EVSTAT, {24'h0, ev});
		ev = 8'h00;
		step(src_raw);
		evm = 8'h00;
		wr(EFIC_IDX_EVMASK, 32'h0);
		run(4);
		chk("hresp", {31'h0, hresp}, 32'h0);
		$display("test irq done");
		finish_test();
	end
endmodule
`default_nettype wire
